/* File: radio_ovr_pkg.sv */
// Constants, register map and lookup tables for the radio override and coefficient register bank
package radio_ovr_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam int          ADDR_W         = 7;
   localparam int          DATA_W         = 8;
   localparam int          NUM_REGS       = 7;
   localparam logic [6:0]  ADDR_BASE      = 7'h65;
   localparam logic [6:0]  ADDR_REG_EN    = 7'h65;
   localparam logic [6:0]  ADDR_REG_LVL   = 7'h66;
   localparam logic [6:0]  ADDR_ADC_A     = 7'h67;
   localparam logic [6:0]  ADDR_ADC_B     = 7'h68;
   localparam logic [6:0]  ADDR_GAIN_A    = 7'h69;
   localparam logic [6:0]  ADDR_GAIN_B    = 7'h6a;
   localparam logic [6:0]  ADDR_COEF_IDX  = 7'h6b;
   localparam logic [6:0]  ADDR_COEF_VAL  = 7'h6c;

   localparam logic [2:0]  SLOT_REG_EN    = 3'h0;
   localparam logic [2:0]  SLOT_REG_LVL   = 3'h1;
   localparam logic [2:0]  SLOT_ADC_A     = 3'h2;
   localparam logic [2:0]  SLOT_ADC_B     = 3'h3;
   localparam logic [2:0]  SLOT_GAIN_A    = 3'h4;
   localparam logic [2:0]  SLOT_GAIN_B    = 3'h5;
   localparam logic [2:0]  SLOT_COEF_IDX  = 3'h6;

   localparam logic [7:0]  RESET_VAL [NUM_REGS] = '{8'h81, 8'h00, 8'h1d, 8'h00, 8'h20, 8'h00, 8'h00};
   localparam logic [7:0]  WRITE_MASK [NUM_REGS] = '{8'hff, 8'hf7, 8'hff, 8'h1f, 8'h3f, 8'hff, 8'h07};
   localparam logic [7:0]  COEF_VAL_MASK  = 8'h3f;
   localparam logic [7:0]  ZERO_BYTE      = 8'h00;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int          BIT_SMART_POR  = 7;
   localparam int          BIT_DIG_PWDN   = 0;
   localparam int          BIT_MASTER     = 7;
   localparam int          BIT_ADC_RESET  = 7;
   localparam int          BIT_TUNE_OVR   = 4;
   localparam int          BIT_OPEN_LOOP  = 3;
   localparam int          BIT_AGC_EN     = 5;
   localparam int          BIT_LNA_HIGH   = 4;
   localparam int          BIT_IGN_PRE    = 7;
   localparam int          BIT_SLOW_INC   = 6;

   // Enable vector order: bias, vco/if/rf/pll/dig ldo, xtal, temp, 32k, ref dac, adc, vcm
   localparam int          NUM_EN         = 12;

   // ***************************************************************
   // Gain and reference tables
   // ***************************************************************
   localparam logic [10:0] ADC_REF_BASE_MV = 11'd500;
   localparam logic [10:0] ADC_REF_STEP_MV = 11'd100;
   localparam logic [4:0]  LNA_MIN_GAIN_DB = 5'd5;
   localparam logic [4:0]  LNA_MAX_GAIN_DB = 5'd25;
   localparam logic [4:0]  PGA_GAIN_DB [16] = '{5'd0, 5'd3, 5'd6, 5'd12, 5'd18, 5'd24, 5'd24, 5'd24,
                                               5'd24, 5'd24, 5'd24, 5'd24, 5'd24, 5'd24, 5'd24, 5'd24};

   // ***************************************************************
   // Transmit shaping table
   // ***************************************************************
   localparam int          COEF_DEPTH     = 8;
   localparam int          COEF_W         = 6;
   localparam logic [5:0]  COEF_RESET [COEF_DEPTH] = '{6'h01, 6'h03, 6'h06, 6'h0a,
                                                      6'h0f, 6'h13, 6'h14, 6'h00};

endpackage

/* File: coef_table_mem.sv */
// Small resettable coefficient memory with registered read data
`timescale 1ns/100ps
module coef_table_mem (
   input  wire logic                        i_clk,
   input  wire logic                        i_reset_n,
   input  wire logic [2:0]                  i_addr,
   input  wire logic                        i_wr,
   input  wire logic [radio_ovr_pkg::COEF_W-1:0] i_wdata,
   input  wire logic                        i_rd,
   output logic      [radio_ovr_pkg::COEF_W-1:0] o_rdata
);
   import radio_ovr_pkg::*;

   logic [COEF_W-1:0] mem_q [COEF_DEPTH];
   logic [COEF_W-1:0] mem_d [COEF_DEPTH];
   logic [COEF_W-1:0] rdata_q;
   logic [COEF_W-1:0] rdata_d;

   always_comb begin
      for (int i = 0; i < COEF_DEPTH; i++) begin
         mem_d[i] = mem_q[i];
      end
      if (i_wr) begin
         mem_d[i_addr] = i_wdata;
      end
      rdata_d = i_rd ? mem_q[i_addr] : rdata_q;
   end

   // Flops rather than a RAM macro: the table must come up loaded at reset
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int i = 0; i < COEF_DEPTH; i++) begin
            mem_q[i] <= COEF_RESET[i];
         end
         rdata_q <= '0;
      end else begin
         for (int i = 0; i < COEF_DEPTH; i++) begin
            mem_q[i] <= mem_d[i];
         end
         rdata_q <= rdata_d;
      end
   end

   assign o_rdata = rdata_q;

endmodule // coef_table_mem

/* File: radio_override_and_coef_regs.sv */
// Override, converter tuning, gain control and transmit shaping register bank
`timescale 1ns/100ps
module radio_override_and_coef_regs (
   input  wire logic                           i_clk,
   input  wire logic                           i_reset_n,
   input  wire logic [radio_ovr_pkg::ADDR_W-1:0] i_reg_addr,
   input  wire logic [radio_ovr_pkg::DATA_W-1:0] i_reg_wdata,
   input  wire logic                           i_reg_wr,
   input  wire logic                           i_reg_rd,
   output logic      [radio_ovr_pkg::DATA_W-1:0] o_reg_rdata,
   output logic                                o_reg_rvalid,
   input  wire logic [radio_ovr_pkg::NUM_EN-1:0] i_auto_enables,
   output logic      [radio_ovr_pkg::NUM_EN-1:0] o_block_enables,
   output logic                                o_smart_por_en,
   input  wire logic                           i_idle_mode,
   output logic                                o_dig_domain_off,
   output logic      [2:0]                     o_dig_ldo_level,
   output logic                                o_adc_reset,
   output logic                                o_adc_open_loop,
   output logic      [10:0]                    o_adc_ref_mv,
   input  wire logic [3:0]                     i_cal_tune,
   output logic      [3:0]                     o_resonator_tune,
   input  wire logic [4:0]                     i_agc_gain,
   input  wire logic                           i_preamble_det,
   output logic                                o_agc_enable,
   output logic                                o_agc_run,
   output logic                                o_agc_slow_increase,
   output logic                                o_lna_gain_high,
   output logic      [4:0]                     o_lna_gain_db,
   output logic      [3:0]                     o_pga_gain_code,
   output logic      [4:0]                     o_pga_gain_db,
   output logic      [1:0]                     o_pga_window_adj,
   input  wire logic [7:0]                     i_rssi_raw,
   output logic      [7:0]                     o_rssi,
   output logic      [2:0]                     o_coef_index
);
   import radio_ovr_pkg::*;

   // ***************************************************************
   // Decode helpers
   // ***************************************************************
   function automatic logic slot_hit(input logic [ADDR_W-1:0] addr);
      slot_hit = (addr >= ADDR_BASE) && (addr < ADDR_COEF_VAL);
   endfunction

   function automatic logic [2:0] slot_of(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] diff;
      diff    = addr - ADDR_BASE;
      slot_of = diff[2:0];
   endfunction

   // Full drive under master override, otherwise only force on
   function automatic logic [NUM_EN-1:0] apply_ovr(input logic [NUM_EN-1:0] ovr,
                                                   input logic [NUM_EN-1:0] auto_en,
                                                   input logic              master);
      apply_ovr = master ? ovr : (ovr | auto_en);
   endfunction

   // ***************************************************************
   // Register storage
   // ***************************************************************
   logic [7:0]        regs_q [NUM_REGS];
   logic [7:0]        regs_d [NUM_REGS];
   logic              wr_reg;
   logic              wr_coef;
   logic              rd_req;
   logic              rd_coef;
   logic [COEF_W-1:0] coef_rdata;

   assign wr_reg  = i_reg_wr && slot_hit(i_reg_addr);
   assign wr_coef = i_reg_wr && (i_reg_addr == ADDR_COEF_VAL);
   // A read issued with a write in the same cycle is dropped
   assign rd_req  = i_reg_rd && !i_reg_wr;
   assign rd_coef = rd_req && (i_reg_addr == ADDR_COEF_VAL);

   always_comb begin
      for (int i = 0; i < NUM_REGS; i++) begin
         regs_d[i] = regs_q[i];
      end
      if (wr_reg) begin
         // Writes to gain bits land even with the loop on; they take effect once it is off
         regs_d[slot_of(i_reg_addr)] = i_reg_wdata & WRITE_MASK[slot_of(i_reg_addr)];
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= RESET_VAL[i];
         end
      end else begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= regs_d[i];
         end
      end
   end

   coef_table_mem u_coef_table (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_addr    (regs_q[SLOT_COEF_IDX][2:0]),
      .i_wr      (wr_coef),
      .i_wdata   (i_reg_wdata[COEF_W-1:0]),
      .i_rd      (rd_coef),
      .o_rdata   (coef_rdata)
   );

   // ***************************************************************
   // Read path, two cycles so the table read can be registered
   // ***************************************************************
   logic [ADDR_W-1:0] rd_addr_q;
   logic [ADDR_W-1:0] rd_addr_d;
   logic              rd_pend_q;
   logic              rd_pend_d;
   logic [7:0]        rdata_q;
   logic [7:0]        rdata_d;
   logic              rvalid_q;
   logic              rvalid_d;
   logic              agc_on;

   assign agc_on = regs_q[SLOT_GAIN_A][BIT_AGC_EN];

   always_comb begin
      rd_pend_d = rd_req;
      rd_addr_d = rd_req ? i_reg_addr : rd_addr_q;
      rvalid_d  = rd_pend_q;
      rdata_d   = rdata_q;
      if (rd_pend_q) begin
         if (rd_addr_q == ADDR_COEF_VAL) begin
            rdata_d = {2'h0, coef_rdata};
         end else if (rd_addr_q == ADDR_GAIN_A && agc_on) begin
            rdata_d = (regs_q[SLOT_GAIN_A] & 8'he0) | {3'h0, i_agc_gain};
         end else if (slot_hit(rd_addr_q)) begin
            rdata_d = regs_q[slot_of(rd_addr_q)];
         end else begin
            rdata_d = ZERO_BYTE;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rd_addr_q <= '0;
         rd_pend_q <= 1'b0;
         rdata_q   <= '0;
         rvalid_q  <= 1'b0;
      end else begin
         rd_addr_q <= rd_addr_d;
         rd_pend_q <= rd_pend_d;
         rdata_q   <= rdata_d;
         rvalid_q  <= rvalid_d;
      end
   end

   assign o_reg_rdata  = rdata_q;
   assign o_reg_rvalid = rvalid_q;

   // ***************************************************************
   // Block controls
   // ***************************************************************
   logic [NUM_EN-1:0] ovr_vec;
   logic              master;
   logic [NUM_EN-1:0] en_q;
   logic [NUM_EN-1:0] en_d;
   logic              dig_off_q;
   logic              dig_off_d;
   logic [10:0]       ref_q;
   logic [10:0]       ref_d;
   logic [3:0]        tune_q;
   logic [3:0]        tune_d;
   logic              run_q;
   logic              run_d;
   logic              lna_q;
   logic              lna_d;
   logic [3:0]        pga_q;
   logic [3:0]        pga_d;
   logic [7:0]        rssi_q;
   logic [7:0]        rssi_d;
   logic [3:0]        comp;

   assign master  = regs_q[SLOT_REG_LVL][BIT_MASTER];
   assign ovr_vec = {regs_q[SLOT_ADC_B][4], regs_q[SLOT_ADC_A][5], regs_q[SLOT_ADC_A][6],
                     regs_q[SLOT_REG_LVL][4], regs_q[SLOT_REG_LVL][5], regs_q[SLOT_REG_LVL][6],
                     regs_q[SLOT_REG_EN][1], regs_q[SLOT_REG_EN][2], regs_q[SLOT_REG_EN][3],
                     regs_q[SLOT_REG_EN][4], regs_q[SLOT_REG_EN][5], regs_q[SLOT_REG_EN][6]};
   assign comp    = regs_q[SLOT_GAIN_B][5:2];

   always_comb begin
      en_d      = apply_ovr(ovr_vec, i_auto_enables, master);
      dig_off_d = regs_q[SLOT_REG_EN][BIT_DIG_PWDN] && i_idle_mode;
      ref_d     = ADC_REF_BASE_MV + 11'(ADC_REF_STEP_MV * regs_q[SLOT_ADC_B][2:0]);
      tune_d    = regs_q[SLOT_ADC_A][BIT_TUNE_OVR] ? regs_q[SLOT_ADC_A][3:0] : i_cal_tune;
      // Without the ignore bit the loop waits for a detected preamble
      run_d     = agc_on && (regs_q[SLOT_GAIN_B][BIT_IGN_PRE] || i_preamble_det);
      lna_d     = agc_on ? i_agc_gain[4] : regs_q[SLOT_GAIN_A][BIT_LNA_HIGH];
      pga_d     = agc_on ? i_agc_gain[3:0] : regs_q[SLOT_GAIN_A][3:0];
      // High front-end gain is backed out of the strength value, floored at zero
      if (lna_q && (i_rssi_raw > {4'h0, comp})) begin
         rssi_d = i_rssi_raw - {4'h0, comp};
      end else if (lna_q) begin
         rssi_d = ZERO_BYTE;
      end else begin
         rssi_d = i_rssi_raw;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         en_q      <= '0;
         dig_off_q <= 1'b0;
         ref_q     <= ADC_REF_BASE_MV;
         tune_q    <= '0;
         run_q     <= 1'b0;
         lna_q     <= 1'b0;
         pga_q     <= '0;
         rssi_q    <= '0;
      end else begin
         en_q      <= en_d;
         dig_off_q <= dig_off_d;
         ref_q     <= ref_d;
         tune_q    <= tune_d;
         run_q     <= run_d;
         lna_q     <= lna_d;
         pga_q     <= pga_d;
         rssi_q    <= rssi_d;
      end
   end

   assign o_block_enables     = en_q;
   assign o_smart_por_en      = regs_q[SLOT_REG_EN][BIT_SMART_POR];
   assign o_dig_domain_off    = dig_off_q;
   assign o_dig_ldo_level     = regs_q[SLOT_REG_LVL][2:0];
   assign o_adc_reset         = regs_q[SLOT_ADC_A][BIT_ADC_RESET];
   assign o_adc_open_loop     = regs_q[SLOT_ADC_B][BIT_OPEN_LOOP];
   assign o_adc_ref_mv        = ref_q;
   assign o_resonator_tune    = tune_q;
   assign o_agc_enable        = agc_on;
   assign o_agc_run           = run_q;
   assign o_agc_slow_increase = regs_q[SLOT_GAIN_B][BIT_SLOW_INC];
   assign o_lna_gain_high     = lna_q;
   assign o_lna_gain_db       = lna_q ? LNA_MAX_GAIN_DB : LNA_MIN_GAIN_DB;
   assign o_pga_gain_code     = pga_q;
   assign o_pga_gain_db       = PGA_GAIN_DB[pga_q];
   assign o_pga_window_adj    = regs_q[SLOT_GAIN_B][1:0];
   assign o_rssi              = rssi_q;
   assign o_coef_index        = regs_q[SLOT_COEF_IDX][2:0];

   // ***************************************************************
   // Checks
   // ***************************************************************
   chk_master_drive: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      master |=> (o_block_enables == $past(ovr_vec)))
      else $error("master override does not drive enables");
   chk_force_on_only: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !master |=> (o_block_enables == ($past(ovr_vec) | $past(i_auto_enables))))
      else $error("override without master not force-on only");
   chk_dig_powerdown: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (regs_q[SLOT_REG_EN][BIT_DIG_PWDN] && i_idle_mode) |=> o_dig_domain_off)
      else $error("digital domain not powered down in idle");
   chk_adc_ref_top: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (regs_q[SLOT_ADC_B][2:0] == 3'h7) |=> (o_adc_ref_mv == 11'd1200))
      else $error("reference code 111 not 1.2 V");
   chk_agc_readback: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (rd_pend_q && rd_addr_q == ADDR_GAIN_A && agc_on) |=> (o_reg_rvalid && o_reg_rdata[4:0] == $past(i_agc_gain)))
      else $error("gain readback not loop result");
   chk_lna_min: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !o_lna_gain_high |-> (o_lna_gain_db == 5'd5))
      else $error("low select not 5 dB");
   chk_pga_max: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (o_pga_gain_code == 4'h5) |-> (o_pga_gain_db == 5'd24))
      else $error("code 101 not 24 dB");
   chk_preamble_ign: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (agc_on && regs_q[SLOT_GAIN_B][BIT_IGN_PRE]) |=> o_agc_run)
      else $error("loop halted despite ignore bit");
   chk_tune_override: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      regs_q[SLOT_ADC_A][BIT_TUNE_OVR] |=> (o_resonator_tune == $past(regs_q[SLOT_ADC_A][3:0])))
      else $error("tuning override ignored");
   // A quiet cycle between write and read keeps the entry from being overwritten
   chk_coef_roundtrip: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (wr_coef ##1 !i_reg_wr ##1 rd_coef) |-> ##2
      (o_reg_rvalid && o_reg_rdata == {2'h0, $past(i_reg_wdata[COEF_W-1:0], 4)}))
      else $error("coefficient read does not return written value");
   chk_reserved_idx: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (o_reg_rvalid && $past(rd_addr_q) == ADDR_COEF_IDX) |-> (o_reg_rdata[7:3] == 5'h00))
      else $error("reserved index bits not zero");
   chk_index_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !(i_reg_wr && i_reg_addr == ADDR_COEF_IDX) |=> $stable(o_coef_index))
      else $error("coefficient index changed without write");
   chk_manual_gain: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !agc_on |=> (o_pga_gain_code == $past(regs_q[SLOT_GAIN_A][3:0])))
      else $error("manual gain code not applied");
   chk_rssi_comp: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (lna_q && i_rssi_raw > {4'h0, comp}) |=> (o_rssi == $past(i_rssi_raw - {4'h0, comp})))
      else $error("strength not compensated at high front-end gain");
   chk_reserved_gain: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (o_reg_rvalid && $past(rd_addr_q) == ADDR_GAIN_A) |-> (o_reg_rdata[7:6] == 2'h0))
      else $error("reserved gain bits not zero");

   cov_coef_read: cover property (@(posedge i_clk) disable iff (!i_reset_n) rd_coef ##2 o_reg_rvalid);
   cov_agc_read: cover property (@(posedge i_clk) disable iff (!i_reset_n)
      (rd_pend_q && rd_addr_q == ADDR_GAIN_A && agc_on));
   cov_master_off: cover property (@(posedge i_clk) disable iff (!i_reset_n) master ##1 !master);
   cov_dig_off: cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(o_dig_domain_off));

endmodule // radio_override_and_coef_regs

/* File: reg_host_model.sv */
// Host-side driver model for the parallel register port of the override bank
`timescale 1ns/100ps
module reg_host_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rvalid,
   output logic      [6:0] o_addr,
   output logic      [7:0] o_wdata,
   output logic            o_wr,
   output logic            o_rd
);
   // ***************************************************************
   // Access tasks
   // ***************************************************************
   initial begin
      o_addr = 7'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   // Released lines show inverted values so stale data never looks valid
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr  <= a;
      o_wdata <= d;
      o_wr    <= 1'b1;
      @(posedge i_clk);
      o_wr    <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~d;
   endtask

   task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge i_clk);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_clk);
      o_rd   <= 1'b0;
      o_addr <= ~a;
      repeat (3) begin
         @(posedge i_clk);
         if (i_rvalid === 1'b1 && !ok) begin
            ok = 1'b1;
            d = i_rdata;
         end
      end
   endtask
endmodule // reg_host_model

/* File: tb_radio_override_and_coef_regs.sv */
// Self-checking testbench for the override and coefficient register bank
`timescale 1ns/100ps
module tb_radio_override_and_coef_regs;
   logic        i_clk = 1'b0;
   logic        i_reset_n = 1'b0;
   logic [6:0]  addr;
   logic [7:0]  wdata, rdata, rssi;
   logic        wr, rd, rvalid, dig_off, agc_run, slow;
   logic [11:0] auto_en = 12'h000;
   logic [11:0] en;
   logic        idle = 1'b1;
   logic        pre = 1'b0;
   logic [3:0]  cal = 4'h6;
   logic [3:0]  tune, pga_code;
   logic [4:0]  agc_g = 5'h00;
   logic [4:0]  lna_db, pga_db;
   logic [10:0] ref_mv;
   logic [7:0]  rssi_raw = 8'h20;
   logic [2:0]  coef_idx;
   logic [2:0]  ldo_lvl;
   logic [1:0]  win;
   logic        spor, adc_rst, oloop, agc_en, lna_hi;
   int          num_errors = 0;
   int          total_checks = 0;
   logic [7:0]  rst_exp [10] = '{8'h00, 8'h81, 8'h00, 8'h1d, 8'h00, 8'h20, 8'h00, 8'h00, 8'h01, 8'h00};
   logic [7:0]  coef_exp [7] = '{8'h01, 8'h03, 8'h06, 8'h0a, 8'h0f, 8'h13, 8'h14};
   logic [7:0]  msk_exp [7] = '{8'h00, 8'hff, 8'hf7, 8'hff, 8'h1f, 8'h2a, 8'hff};
   logic [3:0]  pga_in [4] = '{4'h0, 4'h1, 4'h2, 4'h5};
   logic [4:0]  pga_out [4] = '{5'd0, 5'd3, 5'd6, 5'd24};

   always #4 i_clk = ~i_clk;

   reg_host_model host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr), .o_wdata(wdata),
                        .o_wr(wr), .o_rd(rd));

   radio_override_and_coef_regs DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_auto_enables(auto_en),
      .o_block_enables(en), .o_smart_por_en(spor), .i_idle_mode(idle), .o_dig_domain_off(dig_off),
      .o_dig_ldo_level(ldo_lvl), .o_adc_reset(adc_rst), .o_adc_open_loop(oloop), .o_adc_ref_mv(ref_mv),
      .i_cal_tune(cal), .o_resonator_tune(tune), .i_agc_gain(agc_g), .i_preamble_det(pre), .o_agc_enable(agc_en),
      .o_agc_run(agc_run), .o_agc_slow_increase(slow), .o_lna_gain_high(lna_hi), .o_lna_gain_db(lna_db),
      .o_pga_gain_code(pga_code), .o_pga_gain_db(pga_db), .o_pga_window_adj(win), .i_rssi_raw(rssi_raw),
      .o_rssi(rssi), .o_coef_index(coef_idx));

   // ***************************************************************
   // Checking and closing
   // ***************************************************************
   task automatic report_and_stop;
      if (num_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // A missing read answer shows up as bit 8 set
   task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      host.rd(a, d, ok);
      chk({3'h0, ~ok, d}, {4'h0, exp});
   endtask

   task automatic settle;
      repeat (4) @(posedge i_clk);
   endtask

   initial begin
      repeat (20000) @(posedge i_clk);
      num_errors++;
      report_and_stop();
   end

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial begin
      repeat (12) @(posedge i_clk);
      i_reset_n <= 1'b1;
      foreach (rst_exp[k]) rchk(7'h64 + 7'(k), rst_exp[k]);
      chk(12'({spor, agc_en}), 12'h3);
      foreach (coef_exp[k]) begin
         host.wr(7'h6b, 8'(k));
         rchk(7'h6c, coef_exp[k]);
      end
      host.wr(7'h6b, 8'hfd);
      host.wr(7'h6c, 8'hea);
      rchk(7'h6c, 8'h2a);
      rchk(7'h6b, 8'h05);
      chk(12'(coef_idx), 12'h5);
      host.wr(7'h6b, 8'h04);
      rchk(7'h6c, 8'h0f);
      agc_g <= 5'h0a;
      foreach (msk_exp[k]) begin
         host.wr(7'h64 + 7'(k), 8'hff);
         rchk(7'h64 + 7'(k), msk_exp[k]);
      end
      settle();
      chk(en, 12'hfff);
      chk(12'(ref_mv), 12'd1200);
      chk(12'(tune), 12'hf);
      chk(12'(pga_code), 12'ha);
      chk(12'(slow), 12'h1);
      chk(12'(agc_run), 12'h1);
      chk(12'(dig_off), 12'h1);
      chk({2'h0, spor, ldo_lvl, adc_rst, oloop, agc_en, lna_hi, win}, 12'h3fb);
      // Full override mode must be able to switch blocks off
      auto_en <= 12'h0f0;
      host.wr(7'h65, 8'h01);
      host.wr(7'h66, 8'h80);
      host.wr(7'h67, 8'h00);
      host.wr(7'h68, 8'h00);
      settle();
      chk(en, 12'h000);
      chk(12'(tune), 12'h6);
      chk({2'h0, spor, ldo_lvl, adc_rst, oloop, agc_en, lna_hi, win}, 12'h00b);
      host.wr(7'h66, 8'h00);
      settle();
      chk(en, 12'h0f0);
      host.wr(7'h65, 8'h40);
      settle();
      chk(en, 12'h0f1);
      chk(12'(dig_off), 12'h0);
      for (int c = 0; c < 8; c++) begin
         host.wr(7'h68, 8'(c));
         settle();
         chk(12'(ref_mv), 12'(500 + 100 * c));
      end
      host.wr(7'h6a, 8'h0c);
      foreach (pga_in[k]) begin
         host.wr(7'h69, {4'h0, pga_in[k]});
         settle();
         chk(12'(pga_db), 12'(pga_out[k]));
      end
      chk(12'(lna_db), 12'd5);
      chk(12'(rssi), 12'h20);
      chk(12'(slow), 12'h0);
      host.wr(7'h69, 8'h10);
      settle();
      chk(12'(rssi), 12'h1d);
      chk(12'(lna_hi), 12'h1);
      chk(12'(lna_db), 12'd25);
      rchk(7'h69, 8'h10);
      rssi_raw <= 8'h02;
      settle();
      chk(12'(rssi), 12'h00);
      chk(12'(agc_run), 12'h0);
      host.wr(7'h69, 8'h20);
      settle();
      chk(12'(agc_run), 12'h0);
      pre <= 1'b1;
      settle();
      chk(12'(agc_run), 12'h1);
      report_and_stop();
   end
endmodule // tb_radio_override_and_coef_regs
